// ### delay_channel.sv
// eight independent trigger-logic timing channels with register port
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "delay_channel_defines.svh"

module delay_channel
    import delay_channel_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // external pins
    input  wire logic [7:0]  ext_in,
    input  wire logic        ext_clk,
    output logic      [7:0]  ch_out,
    output logic      [15:0] ch_state,
    // register port
    input  wire logic [8:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata
);

    st_t        q;
    st_t        d;
    cfg_t [7:0] mem_q [`NSLOT];
    logic [7:0] acc_w;
    logic [7:0] lvl_w;
    logic [7:0] crst_w;
    logic [7:0] rearm_w;
    logic       cmd_w;

    // negate, then or/and/xor terms over inputs and outputs
    function automatic logic trig_fn(logic [15:0] v, logic [31:0] a, logic [31:0] b);
        logic [15:0] x;
        x = v ^ b[31:16];
        return (|(x & a[15:0])) | ((a[31:16] != 16'h0) & (&(x | ~a[31:16])))
               | (^(x & b[15:0]));
    endfunction : trig_fn

    // long values switch to the coarse step
    function automatic logic [32:0] ld_fn(logic [31:0] v);
        return (v > `LONG_TICKS) ? {1'b1, v >> `COARSE_SH} : {1'b0, v};
    endfunction : ld_fn

    assign cmd_w   = wr && (addr == `A_CMD);
    assign rearm_w = cmd_w ? wdata[7:0] : 8'h0;
    assign crst_w  = cmd_w ? wdata[15:8] : 8'h0;

    always_comb begin
        ch_t         c;
        cfg_t        g;
        mode_t       m;
        logic [15:0] v;
        logic        it;
        logic        xt;
        logic        tick;
        logic        step;
        logic        lv;
        logic        a;
        logic [31:0] dv;
        c    = '0;
        g    = '0;
        m    = mode_off;
        dv   = '0;
        tick = 1'b0;
        step = 1'b0;
        lv   = 1'b0;
        a    = 1'b0;
        v    = '0;
        it   = 1'b0;
        xt   = 1'b0;
        d    = q;
        acc_w = '0;
        lvl_w = '0;
        // two-stage synchronisers, edge taken from the second stage
        d.in1 = ext_in;
        d.in2 = q.in1;
        d.ex1 = ext_clk;
        d.ex2 = q.ex1;
        d.ex3 = q.ex2;
        it   = (q.tb == 4'(`TICK_CYC - 1));
        d.tb = it ? 4'h0 : q.tb + 4'h1;
        xt   = q.ex2 & !q.ex3;
        for (int i = 0; i < 8; i++) begin
            v[i] = q.in2[i];
            v[i + 8] = q.ch[i].out;
        end
        // each pass touches only its own channel's state
        for (int i = 0; i < `NCH; i++) begin
            c = q.ch[i];
            g = q.cfg[i];
            m = mode_t'(g.ctrl[3:0]);
            tick = g.ctrl[`F_EXT] ? xt : it;
            step = tick & (!c.coarse | (c.pre == 6'(`COARSE_DIV - 1)));
            if (tick & c.coarse)
                c.pre = c.pre + 6'h1;
            lv = trig_fn(v, g.lga, g.lgb);
            lvl_w[i] = lv;
            c.lvl = lv;
            if (tick)
                c.ival = c.ival + 32'h1;
            a = 1'b0;
            if (lv & !q.ch[i].lvl & (m inside {mode_delay, mode_dynamic, mode_toggle,
                    interval_measure_mode})
                    & ((q.ch[i].ph == ph_idle) | (m inside {mode_toggle,
                    interval_measure_mode}))) begin
                if (c.skc < g.trg[7:0])
                    c.skc = c.skc + 8'h1;
                else if (!((g.trg[15:8] != 8'h0) && (c.rtc >= g.trg[15:8]))) begin
                    a = 1'b1;
                    if (g.trg[15:8] != 8'h0)
                        c.rtc = c.rtc + 8'h1;
                end
            end
            acc_w[i] = a;
            // interval restarts on every rising edge so busy time still counts
            if (lv & !q.ch[i].lvl & (m inside {mode_dynamic, interval_measure_mode}))
                c.ival = '0;
            if (a) begin
                unique case (m)
                    mode_delay: begin
                        {c.coarse, c.cnt} = ld_fn(g.dly + c.swp);
                        c.ph = ph_delay;
                    end
                    // fire the lead time before the next expected trigger
                    mode_dynamic: begin
                        dv = (q.ch[i].ival > g.dly) ? q.ch[i].ival - g.dly : 32'h0;
                        {c.coarse, c.cnt} = ld_fn(dv + c.swp);
                        c.ph = ph_delay;
                    end
                    mode_toggle: c.out = !c.out;
                    // store interval, counted in base ticks
                    interval_measure_mode: c.res = q.ch[i].ival;
                    default: ;
                endcase
                if (g.ctrl[`F_SWP])
                    c.swp = c.swp + g.inc;
            end
            if (step & (q.ch[i].ph != ph_idle)) begin
                if (c.cnt > 32'h1)
                    c.cnt = c.cnt - 32'h1;
                else if (q.ch[i].ph == ph_delay) begin
                    c.ph = ph_pulse;
                    c.out = 1'b1;
                    {c.coarse, c.cnt} = ld_fn(g.wid);
                end else if (m == mode_clock) begin
                    // low phase uses the delay value
                    c.ph = ph_delay;
                    c.out = 1'b0;
                    {c.coarse, c.cnt} = ld_fn(g.dly);
                end else begin
                    c.ph = ph_idle;
                    c.out = 1'b0;
                end
            end
            unique case (m)
                mode_off: begin
                    c.ph = ph_idle;
                    c.out = 1'b0;
                end
                mode_fixed: begin
                    c.ph = ph_idle;
                    c.out = g.ctrl[`F_FIX];
                end
                mode_passive: begin
                    c.ph = ph_idle;
                    c.out = lv ^ g.ctrl[`F_INV];
                end
                mode_clock: if (q.ch[i].ph == ph_idle) begin
                    c.ph = ph_pulse;
                    c.out = 1'b1;
                    {c.coarse, c.cnt} = ld_fn(g.wid);
                end
                // qualify the high time, a glitch restarts it
                mode_noise: if (!lv) begin
                    c.qual = 1'b0;
                    if (q.ch[i].ph == ph_idle)
                        c.cnt = '0;
                end else if ((q.ch[i].ph == ph_idle) & !q.ch[i].qual & tick) begin
                    if (q.ch[i].cnt + 32'h1 >= g.dly) begin
                        c.qual = 1'b1;
                        c.ph = ph_pulse;
                        c.out = 1'b1;
                        {c.coarse, c.cnt} = ld_fn(g.wid);
                    end else
                        c.cnt = q.ch[i].cnt + 32'h1;
                end
                default: ;
            endcase
            if (rearm_w[i]) begin
                c.skc = '0;
                c.rtc = '0;
            end
            if (crst_w[i])
                c = '0;
            d.ch[i] = c;
            d.state[2*i +: 2] = (m == mode_off) ? 2'h0
                              : ((c.ph != ph_idle) | c.out) ? 2'h2 : 2'h1;
        end
        if (wr && !addr[8]) begin
            unique case (addr[4:2])
                `R_CTRL:    d.cfg[addr[7:5]].ctrl = wdata[7:0];
                `R_DELAY:   d.cfg[addr[7:5]].dly = wdata;
                `R_WIDTH:   d.cfg[addr[7:5]].wid = wdata;
                `R_LOGIC_A: d.cfg[addr[7:5]].lga = wdata;
                `R_LOGIC_B: d.cfg[addr[7:5]].lgb = wdata;
                `R_TRIGCNT: d.cfg[addr[7:5]].trg = wdata[15:0];
                `R_SWEEP:   d.cfg[addr[7:5]].inc = wdata;
                default: ;
            endcase
        end
        if (cmd_w && wdata[`C_RECALL])
            d.cfg = mem_q[wdata[21:16]];
        d.rdata = '0;
        if (rd) begin
            if (addr == `A_STATUS)
                d.rdata = {q.state, ch_out, 8'h0};
            else if (!addr[8]) begin
                unique case (addr[4:2])
                    `R_CTRL:    d.rdata = {24'h0, q.cfg[addr[7:5]].ctrl};
                    `R_DELAY:   d.rdata = q.cfg[addr[7:5]].dly;
                    `R_WIDTH:   d.rdata = q.cfg[addr[7:5]].wid;
                    `R_LOGIC_A: d.rdata = q.cfg[addr[7:5]].lga;
                    `R_LOGIC_B: d.rdata = q.cfg[addr[7:5]].lgb;
                    `R_TRIGCNT: d.rdata = {16'h0, q.cfg[addr[7:5]].trg};
                    `R_SWEEP:   d.rdata = q.cfg[addr[7:5]].inc;
                    `R_RESULT:  d.rdata = q.ch[addr[7:5]].res;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    // slot store, contents undefined until first save
    always_ff @(posedge clk) begin
        if (cmd_w && wdata[`C_SAVE])
            mem_q[wdata[21:16]] <= q.cfg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++)
            ch_out[i] = q.ch[i].out;
    end
    assign ch_state = q.state;
    assign rdata    = q.rdata;

    mode_t m0;
    assign m0 = mode_t'(q.cfg[0].ctrl[3:0]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_fix;
        m0 == mode_fixed && !crst_w[0] |=> ch_out[0] == $past(q.cfg[0].ctrl[`F_FIX]);
    endproperty
    a_fix: assert property (p_fix) else $error("fixed level wrong");

    property p_pas;
        m0 == mode_passive && !crst_w[0]
            |=> ch_out[0] == ($past(lvl_w[0]) ^ $past(q.cfg[0].ctrl[`F_INV]));
    endproperty
    a_pas: assert property (p_pas) else $error("passive output wrong");

    property p_tog;
        acc_w[2] && mode_t'(q.cfg[2].ctrl[3:0]) == mode_toggle && !crst_w[2]
            |=> ch_out[2] != $past(ch_out[2]);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle missed");

    property p_meas;
        acc_w[4] && mode_t'(q.cfg[4].ctrl[3:0]) == interval_measure_mode && !crst_w[4]
            |=> q.ch[4].res == $past(q.ch[4].ival);
    endproperty
    a_meas: assert property (p_meas) else $error("interval not stored");

    property p_swp;
        acc_w[1] && q.cfg[1].ctrl[`F_SWP] && !crst_w[1]
            |=> q.ch[1].swp == $past(q.ch[1].swp) + $past(q.cfg[1].inc);
    endproperty
    a_swp: assert property (p_swp) else $error("sweep not added");

    property p_rtg;
        q.cfg[1].trg[15:8] != 8'h0 && q.ch[1].rtc >= q.cfg[1].trg[15:8] |-> !acc_w[1];
    endproperty
    a_rtg: assert property (p_rtg) else $error("trigger past limit");

    property p_skip;
        q.ch[1].skc < q.cfg[1].trg[7:0] |-> !acc_w[1];
    endproperty
    a_skip: assert property (p_skip) else $error("skipped trigger accepted");

    property p_rst;
        crst_w[1] |=> !ch_out[1] && q.ch[1].skc == 8'h0 && q.ch[1].swp == 32'h0
            && q.ch[1].ph == ph_idle;
    endproperty
    a_rst: assert property (p_rst) else $error("channel reset incomplete");

    property p_dly;
        $rose(ch_out[1]) && mode_t'(q.cfg[1].ctrl[3:0]) == mode_delay
            |-> $past(q.ch[1].ph) == ph_delay;
    endproperty
    a_dly: assert property (p_dly) else $error("pulse without delay");

    property p_state;
        $past(m0) == mode_off |-> ch_state[1:0] == 2'h0;
    endproperty
    a_state: assert property (p_state) else $error("disabled state wrong");

    property p_dyn;
        acc_w[7] && mode_t'(q.cfg[7].ctrl[3:0]) == mode_dynamic && !crst_w[7]
            |=> q.ch[7].ph == ph_delay && q.ch[7].ival == 32'h0;
    endproperty
    a_dyn: assert property (p_dyn) else $error("dynamic delay not started");

    c_tog:   cover property (acc_w[2] && mode_t'(q.cfg[2].ctrl[3:0]) == mode_toggle);
    c_clk:   cover property (mode_t'(q.cfg[3].ctrl[3:0]) == mode_clock ##1 $fell(ch_out[3]));
    c_noise: cover property (mode_t'(q.cfg[5].ctrl[3:0]) == mode_noise ##1 $rose(ch_out[5]));
    c_meas:  cover property (acc_w[4] && mode_t'(q.cfg[4].ctrl[3:0]) == interval_measure_mode);
    c_dyn:   cover property (acc_w[7] && mode_t'(q.cfg[7].ctrl[3:0]) == mode_dynamic);

endmodule : delay_channel

// ### delay_channel_defines.svh
// timing counts, register offsets and field positions for the delay channels
`ifndef DELAY_CHANNEL_DEFINES_SVH
`define DELAY_CHANNEL_DEFINES_SVH

`define CLK_NS      5
`define RES_NS      10
`define TICK_CYC    (`RES_NS / `CLK_NS)
`define LONG_S      20
`define LONG_TICKS  32'(64'(`LONG_S) * 64'd1000000000 / 64'(`RES_NS))
`define COARSE_NS   640
`define COARSE_DIV  (`COARSE_NS / `RES_NS)
`define COARSE_SH   $clog2(`COARSE_DIV)
`define NCH         8
`define NSLOT       64

// per-channel word index, channel n at byte 0x20*n
`define R_CTRL      3'h0
`define R_DELAY     3'h1
`define R_WIDTH     3'h2
`define R_LOGIC_A   3'h3
`define R_LOGIC_B   3'h4
`define R_TRIGCNT   3'h5
`define R_SWEEP     3'h6
`define R_RESULT    3'h7
`define A_CMD       9'h100
`define A_STATUS    9'h104

// control word fields
`define F_EXT       4
`define F_FIX       5
`define F_INV       6
`define F_SWP       7
// command word fields
`define C_SAVE      22
`define C_RECALL    23

`endif

// ### delay_channel_pkg.sv
// types shared by the delay channel block
package delay_channel_pkg;

    typedef enum logic [3:0] {
        mode_off, mode_delay, mode_dynamic, mode_toggle, mode_noise,
        mode_fixed, mode_passive, mode_clock, interval_measure_mode
    } mode_t;

    typedef enum logic [1:0] {ph_idle, ph_delay, ph_pulse} phase_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [31:0] dly;
        logic [31:0] wid;
        logic [31:0] lga;
        logic [31:0] lgb;
        logic [15:0] trg;
        logic [31:0] inc;
    } cfg_t;

    typedef struct packed {
        phase_t      ph;
        logic [31:0] cnt;
        logic        coarse;
        logic [5:0]  pre;
        logic [31:0] ival;
        logic [31:0] res;
        logic [31:0] swp;
        logic [7:0]  skc;
        logic [7:0]  rtc;
        logic        out;
        logic        lvl;
        logic        qual;
    } ch_t;

    typedef struct packed {
        cfg_t [7:0]  cfg;
        ch_t  [7:0]  ch;
        logic [7:0]  in1;
        logic [7:0]  in2;
        logic        ex1;
        logic        ex2;
        logic        ex3;
        logic [3:0]  tb;
        logic [31:0] rdata;
        logic [15:0] state;
    } st_t;

endpackage : delay_channel_pkg

// ### ext_src.sv
// trigger source and external timebase standing at the channel pins
`timescale 1ns/1ps
module ext_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // bench side
    input  wire logic [7:0] lvl,
    input  wire logic       xen,
    // device pins
    output logic      [7:0] ext_in,
    output logic            ext_clk
);
    logic [2:0] div_q;
    // sources drive the level straight onto the input pins
    assign ext_in = lvl;
    // timebase toggles every 5 clk; it stands still when not enabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q   <= 3'h0;
            ext_clk <= 1'b0;
        end else if (xen) begin
            div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
            if (div_q == 3'h4) ext_clk <= ~ext_clk;
        end
    end
endmodule : ext_src

// ### delay_channel_test.sv
// self-checking bench for the eight delay channels
`timescale 1ns/1ps
`include "delay_channel_defines.svh"
module delay_channel_test;
    typedef struct {logic [7:0] ctrl; logic [31:0] a, b; logic [7:0] inp; logic exp;} row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  lvl = 8'h00;
    logic        xen = 1'b0;
    logic [7:0]  ext_in;
    logic        ext_clk;
    logic [7:0]  ch_out;
    logic [15:0] ch_state;
    logic [8:0]  addr = 9'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    int          err_count = 0;
    int          num_checks = 0;
    int          l1, l2, w;
    row_t rows [9] = '{
        '{8'h25, 32'h0, 32'h0, 8'h00, 1'b1}, '{8'h05, 32'h1, 32'h0, 8'hFF, 1'b0},
        '{8'h06, 32'h1, 32'h0, 8'h01, 1'b1}, '{8'h46, 32'h1, 32'h0, 8'h01, 1'b0},
        '{8'h06, 32'h0003_0000, 32'h0, 8'h01, 1'b0},
        '{8'h06, 32'h0003_0000, 32'h0, 8'h03, 1'b1},
        '{8'h06, 32'h0, 32'h3, 8'h01, 1'b1}, '{8'h06, 32'h0, 32'h3, 8'h03, 1'b0},
        '{8'h06, 32'h1, 32'h0001_0000, 8'h00, 1'b1}};

    always #2.5 clk = ~clk;

    ext_src u_src (.clk(clk), .rst_b(rst_b), .lvl(lvl), .xen(xen),
                   .ext_in(ext_in), .ext_clk(ext_clk));
    delay_channel u_dut (.clk(clk), .rst_b(rst_b), .ext_in(ext_in), .ext_clk(ext_clk),
                         .ch_out(ch_out), .ch_state(ch_state), .addr(addr),
                         .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // channel c: control, delay, width, or-mask on its own input, trigger counts
    task automatic cfg(input int c, input logic [7:0] ct, input logic [31:0] d, ww, t);
        wr_reg({1'b0, 3'(c), `R_DELAY, 2'b00}, d);
        wr_reg({1'b0, 3'(c), `R_WIDTH, 2'b00}, ww);
        wr_reg({1'b0, 3'(c), `R_LOGIC_A, 2'b00}, 32'h1 << c);
        wr_reg({1'b0, 3'(c), `R_TRIGCNT, 2'b00}, t);
        wr_reg({1'b0, 3'(c), `R_CTRL, 2'b00}, {24'h0, ct});
    endtask : cfg

    // raise input c for hold cycles; latency and length of the output pulse
    task automatic trig(input int c, input int hold, output int lat, output int wid);
        lat = 0;
        wid = 0;
        @(posedge clk);
        lvl[c] <= 1'b1;
        for (int n = 1; n < 400; n++) begin
            @(posedge clk);
            if (n == hold) lvl[c] <= 1'b0;
            #1;
            if (ch_out[c] === 1'b1) begin
                if (lat == 0) lat = n;
                wid++;
            end else if (lat != 0 && n > hold) break;
        end
    endtask : trig

    task automatic run_len(input int c, input logic val, output int n);
        n = 0;
        for (int i = 0; i < 100 && ch_out[c] === val; i++) begin
            @(posedge clk);
            #1;
            n++;
        end
        // a level that never ends counts as a mismatch
        if (n == 100) chk(32'(n), 32'h0);
    endtask : run_len

    task automatic results();
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(32'(ch_out), 32'h0);
        chk(32'(ch_state), 32'h0);
        rd_reg(9'h1F0, v);
        chk(v, 32'h0);
        // logic terms, fixed and passive on channel 0
        foreach (rows[i]) begin
            wr_reg({4'h0, `R_LOGIC_A, 2'b00}, rows[i].a);
            wr_reg({4'h0, `R_LOGIC_B, 2'b00}, rows[i].b);
            wr_reg({4'h0, `R_CTRL, 2'b00}, {24'h0, rows[i].ctrl});
            lvl <= rows[i].inp;
            repeat (6) @(posedge clk);
            #1;
            chk(32'(ch_out[0]), 32'(rows[i].exp));
        end
        lvl <= 8'h00;
        wr_reg({4'h0, `R_CTRL, 2'b00}, 32'h0);
        // delay mode, 4 ticks then 3 ticks high
        cfg(1, 8'h01, 32'd4, 32'd3, 32'h0);
        // state follows the mode one cycle after the write
        @(posedge clk);
        #1;
        chk(32'(ch_state[3:2]), 32'h1);
        trig(1, 4, l1, w);
        chk(32'(l1 >= 10 && l1 <= 14), 32'h1);
        chk(w, 32'd6);
        // sweep adds 2 ticks per trigger
        cfg(1, 8'h81, 32'd4, 32'd1, 32'h0);
        wr_reg({4'h1, `R_SWEEP, 2'b00}, 32'd2);
        trig(1, 4, l1, w);
        trig(1, 4, l2, w);
        chk(32'(l2 - l1 >= 3 && l2 - l1 <= 5), 32'h1);
        // reset clears sweep offset
        wr_reg(`A_CMD, 32'h0000_0200);
        wr_reg({4'h1, `R_CTRL, 2'b00}, 32'h01);
        trig(1, 4, l2, w);
        chk(32'(l2 - l1 >= -1 && l2 - l1 <= 1), 32'h1);
        // retrigger limit 2, then rearm
        cfg(1, 8'h01, 32'd1, 32'd1, 32'h0200);
        for (int k = 0; k < 3; k++) begin
            trig(1, 4, l1, w);
            chk(32'(l1 != 0), 32'(k < 2));
        end
        wr_reg(`A_CMD, 32'h0000_0002);
        trig(1, 4, l1, w);
        chk(32'(l1 != 0), 32'h1);
        // skip first two triggers
        cfg(1, 8'h01, 32'd1, 32'd1, 32'h0002);
        wr_reg(`A_CMD, 32'h0000_0002);
        for (int k = 0; k < 3; k++) begin
            trig(1, 4, l1, w);
            chk(32'(l1 != 0), 32'(k == 2));
        end
        // toggle, then channel reset drops the output
        cfg(2, 8'h03, 32'd0, 32'd0, 32'h0);
        for (int k = 0; k < 3; k++) begin
            trig(2, 4, l1, w);
            chk(32'(ch_out[2]), 32'(k != 1));
        end
        wr_reg(`A_CMD, 32'h0000_0400);
        #1;
        chk(32'(ch_out[2]), 32'h0);
        // clock mode: 2 ticks high, 3 low
        cfg(3, 8'h07, 32'd3, 32'd2, 32'h0);
        run_len(3, 1'b0, w);
        run_len(3, 1'b1, w);
        run_len(3, 1'b0, l1);
        run_len(3, 1'b1, w);
        chk(w, 32'd4);
        chk(l1, 32'd6);
        // interval of 400 clk between trigger starts
        cfg(4, 8'h08, 32'd0, 32'd1, 32'h0);
        trig(4, 4, l1, w);
        trig(4, 4, l1, w);
        rd_reg({4'h4, `R_RESULT, 2'b00}, v);
        chk(32'(v >= 199 && v <= 201), 32'h1);
        // noise: short high ignored, long high qualifies
        cfg(5, 8'h04, 32'd5, 32'd2, 32'h0);
        trig(5, 4, l1, w);
        chk(32'(l1 != 0), 32'h0);
        trig(5, 30, l1, w);
        chk(w, 32'd4);
        // external timebase, 10 clk per tick
        xen <= 1'b1;
        cfg(6, 8'h11, 32'd2, 32'd2, 32'h0);
        trig(6, 4, l1, w);
        chk(32'(w >= 19 && w <= 21), 32'h1);
        xen <= 1'b0;
        // dynamic: edges 200 clk apart, lead 20 ticks, so 80 ticks to the pulse
        cfg(7, 8'h02, 32'd20, 32'd1, 32'h0);
        // cleared interval keeps the first edge from loading a huge delay
        wr_reg(`A_CMD, 32'h0000_8000);
        @(posedge clk);
        lvl[7] <= 1'b1;
        repeat (4) @(posedge clk);
        lvl[7] <= 1'b0;
        repeat (195) @(posedge clk);
        trig(7, 4, l1, w);
        chk(32'(l1 >= 159 && l1 <= 167), 32'h1);
        chk(w, 32'd2);
        // save all settings to slot 5, change one, recall brings it back
        wr_reg(`A_CMD, 32'h0045_0000);
        wr_reg({4'h1, `R_DELAY, 2'b00}, 32'h0000_1234);
        rd_reg({4'h1, `R_DELAY, 2'b00}, v);
        chk(v, 32'h0000_1234);
        wr_reg(`A_CMD, 32'h0085_0000);
        rd_reg({4'h1, `R_DELAY, 2'b00}, v);
        chk(v, 32'h0000_0001);
        // clock channel 3 busy, off channel 0 disabled, the rest armed
        rd_reg(`A_STATUS, v);
        chk(32'(v[31:16]), 32'h0000_5594);
        // only the free-running clock output may be high
        chk(32'(v[15:0] & 16'hF7FF), 32'h0);
        results();
    end
endmodule : delay_channel_test
